// *** logic/dpl_cfg.svh ***
`ifndef DPL_CFG_SVH
`define DPL_CFG_SVH

// Register byte addresses
// Word index times four, since one index is not word aligned
`define DPL_FINE_ADDR        12'h1cc
`define DPL_FINE_IDX         8'h73
`define DPL_COARSE_ADDR      12'h1d0
`define DPL_COARSE_IDX       8'h74
`define DPL_STAT_ADDR        12'h080
`define DPL_INT_STAT_ADDR    12'h084
`define DPL_INT_MASK_ADDR    12'h088
`define DPL_ADDR_W           12

// Reset values
`define DPL_FINE_RST         8'ha2
`define DPL_COARSE_RST       8'h85
`define DPL_INT_MASK_RST     2'h0

// Field positions, fine register
`define DPL_FINE_EN_BIT      7
`define DPL_NOACT_BIT        6
`define DPL_NARROW_BIT       5
`define DPL_FINE_WIN_MSB     2
// Field positions, coarse register
`define DPL_COARSE_EN_BIT    7
`define DPL_WIDE_BIT         6
`define DPL_MULTI_BIT        5
`define DPL_COARSE_LIM_MSB   3

// Status bits
`define DPL_ST_LOCK_BIT      0
`define DPL_ST_LOSS_BIT      1

// Lock qualify time in ns and derived cycles at 200 MHz
`define DPL_CLK_MHZ          200
`define DPL_LOCK_QUAL_NS     1000
`define DPL_LOCK_QUAL_CYC    ((`DPL_LOCK_QUAL_NS * `DPL_CLK_MHZ + 999) / 1000)

// Phase error scaling: fine window step, one UI in error units
`define DPL_FINE_STEP        16'h0010
`define DPL_UI_UNITS         16'h0100

`endif

// *** logic/dpl_pkg.sv ***
package dpl_pkg;
  typedef logic [7:0]  dpl_byte_t;
  typedef logic [15:0] dpl_err_t;

  typedef enum logic [2:0] {
    DPL_ST_LOST   = 3'b001,
    DPL_ST_QUAL   = 3'b010,
    DPL_ST_LOCKED = 3'b100
  } dpl_lock_e;
endpackage

// *** logic/dpl_sync.sv ***
`timescale 1ns/1ps
module dpl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dpl_sync_s;

  dpl_sync_s state_reg;
  dpl_sync_s state_next;

  // Two stage chain, first stage feeds only the second
  always_comb begin
    state_next    = state_reg;
    state_next.s1 = d;
    state_next.s2 = state_reg.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q = state_reg.s2;
endmodule // dpl_sync

// *** logic/dpl_top.sv ***
`timescale 1ns/1ps
`include "dpl_cfg.svh"
module dpl_top #(
  parameter int LOCK_QUAL_CYC = `DPL_LOCK_QUAL_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire dpl_pkg::dpl_err_t     phase_err,
  input  wire logic                  phase_valid,
  input  wire logic                  ref_inactive,
  output logic                       phase_locked,
  output logic                       phase_lost,
  output logic                       irq
);
  import dpl_pkg::*;

  localparam int CW = $clog2(LOCK_QUAL_CYC + 1);

  typedef struct packed {
    dpl_byte_t   fine;
    dpl_byte_t   coarse;
    logic [1:0]  int_stat;
    logic [1:0]  int_mask;
    dpl_lock_e   lock;
    logic [CW-1:0] dwell;
    logic [31:0] rdata;
    logic        locked;
    logic        lost;
  } dpl_top_s;

  dpl_top_s state_reg;
  dpl_top_s state_next;

  logic       inact_sync;
  logic       fine_exc;
  logic       coarse_exc;
  logic       excursion;
  logic       access;
  logic       wr;
  logic       rd;
  logic [11:0] addr;
  logic       addr_ok;
  dpl_err_t   phase_mag;

  // Inactivity flag comes from another domain
  dpl_sync #(
    .W (1)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (ref_inactive),
    .q   (inact_sync)
  );

  // Magnitude of signed phase error
  assign phase_mag = phase_err[15] ? dpl_err_t'(~phase_err + 16'h0001) : phase_err;

  dpl_window u_window (
    .fine_en    (state_reg.fine[`DPL_FINE_EN_BIT]),
    .fine_win   (state_reg.fine[`DPL_FINE_WIN_MSB:0]),
    .coarse_en  (state_reg.coarse[`DPL_COARSE_EN_BIT]),
    .coarse_lim (state_reg.coarse[`DPL_COARSE_LIM_MSB:0]),
    .phase_mag  (phase_mag),
    .fine_out   (fine_exc),
    .coarse_out (coarse_exc)
  );

  // Any enabled detector while phase_valid is high, or inactivity when its trigger is set
  assign excursion = phase_valid && (fine_exc || coarse_exc)
                     || (inact_sync && state_reg.fine[`DPL_NOACT_BIT]);

  // APB decode, single cycle answer
  assign access  = psel && penable;
  assign wr      = access && pwrite;
  assign rd      = access && !pwrite;
  assign addr    = paddr[`DPL_ADDR_W-1:0];
  assign addr_ok = (paddr[31:`DPL_ADDR_W] == '0) && (addr == `DPL_FINE_ADDR ||
                   addr == `DPL_COARSE_ADDR || addr == `DPL_STAT_ADDR ||
                   addr == `DPL_INT_STAT_ADDR || addr == `DPL_INT_MASK_ADDR);
  assign pready  = 1'b1;
  assign pslverr = access && !addr_ok;

  // Next state: registers, lock tracking, sticky events
  always_comb begin
    logic [1:0] ev;
    ev         = 2'h0;
    state_next = state_reg;

    // Register writes
    if (wr) begin
      case (addr)
        `DPL_FINE_ADDR:     state_next.fine     = pwdata[7:0];
        `DPL_COARSE_ADDR:   state_next.coarse   = pwdata[7:0];
        `DPL_INT_MASK_ADDR: state_next.int_mask = pwdata[1:0];
        `DPL_INT_STAT_ADDR: state_next.int_stat = state_reg.int_stat & ~pwdata[1:0];
        default: ;
      endcase
    end

    // Lock qualification: dwell before lock, immediate loss
    case (state_reg.lock)
      DPL_ST_LOST: begin
        state_next.dwell = '0;
        if (!excursion) begin
          state_next.lock = DPL_ST_QUAL;
        end
      end
      DPL_ST_QUAL: begin
        if (excursion) begin
          state_next.lock  = DPL_ST_LOST;
          state_next.dwell = '0;
        end else if (state_reg.dwell >= CW'(LOCK_QUAL_CYC - 1)) begin
          state_next.lock = DPL_ST_LOCKED;
          ev[`DPL_ST_LOCK_BIT] = 1'b1;
        end else begin
          state_next.dwell = state_reg.dwell + CW'(1);
        end
      end
      DPL_ST_LOCKED: begin
        if (excursion) begin
          state_next.lock  = DPL_ST_LOST;
          state_next.dwell = '0;
          ev[`DPL_ST_LOSS_BIT] = 1'b1;
        end
      end
      default: begin
        state_next.lock  = DPL_ST_LOST;
        state_next.dwell = '0;
      end
    endcase

    // Registered indications follow the tracker
    state_next.locked = (state_next.lock == DPL_ST_LOCKED);
    state_next.lost   = (state_next.lock != DPL_ST_LOCKED);

    // Set wins over a same-cycle clear
    state_next.int_stat = state_next.int_stat | ev;

    // Read data captured in the access phase, held in rdata from the next cycle and not driven to prdata
    state_next.rdata = 32'h0;
    if (rd) begin
      case (addr)
        `DPL_FINE_ADDR:     state_next.rdata = {24'h0, state_reg.fine};
        `DPL_COARSE_ADDR:   state_next.rdata = {24'h0, state_reg.coarse};
        `DPL_STAT_ADDR:     state_next.rdata = {30'h0, state_reg.lost, state_reg.locked};
        `DPL_INT_STAT_ADDR: state_next.rdata = {30'h0, state_reg.int_stat};
        `DPL_INT_MASK_ADDR: state_next.rdata = {30'h0, state_reg.int_mask};
        default:            state_next.rdata = 32'h0;
      endcase
    end
  end

  // Read data must be valid in the access cycle itself
  always_comb begin
    prdata = 32'h0;
    if (rd) begin
      case (addr)
        `DPL_FINE_ADDR:     prdata = {24'h0, state_reg.fine};
        `DPL_COARSE_ADDR:   prdata = {24'h0, state_reg.coarse};
        `DPL_STAT_ADDR:     prdata = {30'h0, state_reg.lost, state_reg.locked};
        `DPL_INT_STAT_ADDR: prdata = {30'h0, state_reg.int_stat};
        `DPL_INT_MASK_ADDR: prdata = {30'h0, state_reg.int_mask};
        default:            prdata = 32'h0;
      endcase
    end
  end

  // State register with documented reset values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg          <= '0;
      state_reg.fine     <= `DPL_FINE_RST;
      state_reg.coarse   <= `DPL_COARSE_RST;
      state_reg.int_mask <= `DPL_INT_MASK_RST;
      state_reg.lock     <= DPL_ST_LOST;
      state_reg.lost     <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign phase_locked = state_reg.locked;
  assign phase_lost   = state_reg.lost;
  assign irq          = |(state_reg.int_stat & state_reg.int_mask);
endmodule // dpl_top

// *** logic/dpl_window.sv ***
`timescale 1ns/1ps
`include "dpl_cfg.svh"
module dpl_window (
  input  wire logic            fine_en,
  input  wire logic [2:0]      fine_win,
  input  wire logic            coarse_en,
  input  wire logic [3:0]      coarse_lim,
  input  wire dpl_pkg::dpl_err_t phase_mag,
  output logic                 fine_out,
  output logic                 coarse_out
);
  import dpl_pkg::*;

  // Window grows with code: code 0 smallest, 7 largest
  function automatic dpl_err_t win_limit(input logic [2:0] code);
    win_limit = dpl_err_t'(`DPL_FINE_STEP * {13'h0, code});
  endfunction

  // Coarse limit in whole input cycles
  function automatic dpl_err_t ui_limit(input logic [3:0] n);
    ui_limit = dpl_err_t'(`DPL_UI_UNITS * {12'h0, n});
  endfunction

  // Excursion detectors, each gated by its enable
  always_comb begin
    fine_out   = fine_en && (phase_mag > win_limit(fine_win));
    coarse_out = coarse_en && (phase_mag > ui_limit(coarse_lim));
  end
endmodule // dpl_window

// *** tb/dpl_checker.sv ***
`timescale 1ns/1ps
`include "dpl_cfg.svh"
module dpl_checker #(
  parameter int LOCK_QUAL_CYC = 4
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire dpl_pkg::dpl_err_t phase_err,
  input wire logic              phase_valid,
  input wire logic              phase_locked,
  input wire logic              phase_lost
);
  import dpl_pkg::*;
  logic [7:0]  fine_reg;
  logic [7:0]  coarse_reg;
  logic [15:0] clean_reg;
  logic        rd_f;
  logic        rd_c;
  logic        exc_f;
  logic        exc_c;
  int          mag;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Excursion seen from the ports
  always_comb begin
    mag = int'($signed(phase_err));
    if (mag < 0) mag = -mag;
    exc_f = phase_valid & fine_reg[7] & (mag > 16 * fine_reg[2:0]);
    exc_c = phase_valid & coarse_reg[7] & (mag > 256 * coarse_reg[3:0]);
    rd_f = psel & penable & (paddr == 32'(`DPL_FINE_ADDR));
    rd_c = psel & penable & (paddr == 32'(`DPL_COARSE_ADDR));
  end
  // Shadow registers and clean-run count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fine_reg <= `DPL_FINE_RST;
      coarse_reg <= `DPL_COARSE_RST;
      clean_reg <= '0;
    end else begin
      if (rd_f && pwrite) fine_reg <= pwdata[7:0];
      if (rd_c && pwrite) coarse_reg <= pwdata[7:0];
      clean_reg <= (exc_f | exc_c) ? '0 : clean_reg + 16'h0001;
    end
  end
  a_lost_inverse: assert property (phase_lost == !phase_locked)
    else $error("lost flag not inverse of locked");
  a_fine_loss: assert property (phase_locked && exc_f |-> ##[1:3] phase_lost)
    else $error("fine excursion kept lock");
  a_coarse_loss: assert property (phase_locked && exc_c |-> ##[1:3] phase_lost)
    else $error("coarse excursion kept lock");
  a_lock_dwell: assert property ($rose(phase_locked) |-> clean_reg >= LOCK_QUAL_CYC)
    else $error("lock without dwell");
  a_lock_holds: assert property (phase_locked && !(exc_f | exc_c) && !$past(exc_f | exc_c)
    && !$past(exc_f | exc_c, 2) |=> phase_locked)
    else $error("lock dropped without excursion");
  a_fine_read: assert property (rd_f && !pwrite |-> prdata == {24'h0, fine_reg})
    else $error("fine register read wrong");
  a_coarse_read: assert property (rd_c && !pwrite |-> prdata == {24'h0, coarse_reg})
    else $error("coarse register read wrong");
  a_mapped_ok: assert property (rd_f || rd_c |-> !pslverr)
    else $error("error on mapped register");
endmodule // dpl_checker

bind dpl_top dpl_checker #(.LOCK_QUAL_CYC(LOCK_QUAL_CYC)) i_dpl_checker (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .phase_err(phase_err),
  .phase_valid(phase_valid), .phase_locked(phase_locked), .phase_lost(phase_lost));

// *** tb/dpll_phase_loss_limits_tb.sv ***
`timescale 1ns/1ps
`include "dpl_cfg.svh"
module dpll_phase_loss_limits_tb;
  import dpl_pkg::*;
  localparam int P = 4;
  logic        clk = 0;
  logic        rst = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic        phase_valid = 0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic        phase_locked;
  logic        phase_lost;
  logic        irq;
  dpl_err_t    phase_err = '0;
  int          mismatches = 0;
  int          num_checks = 0;
  int          m_fine = 'ha2;
  int          m_coarse = 'h85;
  int          m_clean = 0;
  int          m_lock = 0;
  // Clock at 200 MHz
  always #2.5 clk = ~clk;
  dpl_top #(.LOCK_QUAL_CYC(P)) i_dpl_top (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_err(phase_err), .phase_valid(phase_valid), .ref_inactive(1'b0),
    .phase_locked(phase_locked), .phase_lost(phase_lost), .irq(irq));
  // Compare and count
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One APB transfer, waits for pready under a bound
  task automatic apb(logic w, logic [11:0] a, int d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= 32'(a);
    pwdata <= 32'(d);
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        mismatches++;
        summarize();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdchk(logic [11:0] a, int e);
    apb(0, a, 0);
    check(rd, 32'(e));
  endtask
  // Reference excursion test
  function automatic bit exc(int e);
    int m;
    m = e < 0 ? -e : e;
    return (m_fine[7] && m > 16 * (m_fine & 7)) || (m_coarse[7] && m > 256 * (m_coarse & 15));
  endfunction
  // Hold a phase error, then compare lock flags with the model
  task automatic run(int e, int n);
    repeat (n) begin
      @(posedge clk);
      phase_err <= 16'(e);
      phase_valid <= 1;
      m_clean = exc(e) ? 0 : m_clean + 1;
      if (m_clean == 0) m_lock = 0;
      else if (m_clean > P + 2) m_lock = 1;
    end
    repeat (3) @(posedge clk);
    check(32'(phase_locked), 32'(m_lock));
    check(32'(phase_lost), 32'(!m_lock));
  endtask
  // Main sequence
  initial begin
    int v;
    void'($urandom(4971));
    repeat (8) @(posedge clk);
    rst <= 0;
    rdchk(`DPL_FINE_ADDR, 'ha2);
    rdchk(`DPL_COARSE_ADDR, 'h85);
    apb(0, 12'h07c, 0);
    check({rd[30:0], er}, 1);
    repeat (3) begin
      m_coarse = $urandom;
      apb(1, `DPL_COARSE_ADDR, m_coarse);
      m_coarse &= 255;
      rdchk(`DPL_COARSE_ADDR, m_coarse);
    end
    m_coarse = 'h05;
    apb(1, `DPL_COARSE_ADDR, m_coarse);
    for (int c = 1; c < 8; c++) begin
      m_fine = 'ha0 | c;
      apb(1, `DPL_FINE_ADDR, m_fine);
      run(0, P + 4);
      v = int'($urandom_range(16 * c));
      run(c[0] ? v : -v, 4);
      run(16 * c, 4);
      run(-16 * c - 1 - int'($urandom_range(15)), 3);
    end
    m_fine = 'h27;
    m_coarse = 'h81;
    apb(1, `DPL_FINE_ADDR, m_fine);
    apb(1, `DPL_COARSE_ADDR, m_coarse);
    run(0, P + 4);
    run(255, 4);
    run(-257, 3);
    m_coarse = 'h0f;
    apb(1, `DPL_COARSE_ADDR, m_coarse);
    run(0, P + 4);
    run(-3000, 4);
    rdchk(`DPL_STAT_ADDR, 1);
    #1 check(32'(irq), 0);
    apb(1, `DPL_INT_MASK_ADDR, 3);
    #1 check(32'(irq), 1);
    rdchk(`DPL_INT_MASK_ADDR, 3);
    rdchk(`DPL_INT_STAT_ADDR, 3);
    apb(1, `DPL_INT_STAT_ADDR, 3);
    #1 check(32'(irq), 0);
    rdchk(`DPL_INT_STAT_ADDR, 0);
    summarize();
  end
endmodule // dpll_phase_loss_limits_tb
